// ==== src/cri_device_end.sv ====
`timescale 1ns/100ps
`default_nettype none

module cri_device_end (
   // Clock and reset.
   input  wire logic        i_clock,
   input  wire logic        i_sys_rst,
   // Avalon-MM slave.
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   // Interrupt.
   output logic             o_irq,
   // Link to the requester.
   cri_link_if.dev          lnk
);

   // =====================================================================
   // State.
   typedef struct packed {
      cri_pkg::cri_dev_state_e st;
      logic [11:0][15:0]       blk;
      logic [7:0]              cnt;
      logic [31:0]             ctrl;
      logic [2:0]              ists;
      logic [2:0]              imsk;
      logic [15:0]             last_cmd;
      logic [15:0]             last_sts;
      logic                    ack;
      logic                    st_we;
      logic [2:0]              area;
      logic [15:0]             offs;
      logic [15:0]             word;
      logic                    bus_ack;
      logic [31:0]             rdata;
   } cri_dev_s;

   cri_dev_s s_r;
   cri_dev_s s_nxt;

   // =====================================================================
   // Required data block size of each implemented command, zero if none.
   function automatic logic [15:0] cri_cmd_size(input logic [15:0] cmd);
      logic [15:0] sz;
      sz = 16'h0000;
      unique case (cmd)
         cri_pkg::CMD_SETQ:  sz = 16'h0003;
         cri_pkg::CMD_CLRD:  sz = 16'h0001;
         cri_pkg::CMD_RDD:   sz = 16'h0006;
         cri_pkg::CMD_RDREG: sz = 16'h0006;
         cri_pkg::CMD_RDIN:  sz = 16'h0006;
         cri_pkg::CMD_RDOUT: sz = 16'h0006;
         cri_pkg::CMD_RDQ:   sz = 16'h0006;
         cri_pkg::CMD_BITWR: sz = 16'h0004;
         cri_pkg::CMD_WRREG: sz = 16'h0006;
         cri_pkg::CMD_WRIN:  sz = 16'h0006;
         cri_pkg::CMD_WROUT: sz = 16'h0006;
         default:            sz = 16'h0000;
      endcase
      return sz;
   endfunction : cri_cmd_size

   // =====================================================================
   // Decode of the latched command block.
   logic [15:0] cmd;
   logic [15:0] len;
   logic [15:0] mode;
   logic [15:0] styp;
   logic [15:0] need;
   logic [1:0]  role;
   logic        link_ok;
   logic [7:0]  maj;
   logic [2:0]  area;
   logic        area_ok;
   logic [31:0] wmask;
   logic        acc;

   always_comb begin
      cmd     = s_r.blk[cri_pkg::W_CMD];
      len     = s_r.blk[cri_pkg::W_LEN];
      mode    = s_r.blk[cri_pkg::W_MODE];
      styp    = s_r.blk[cri_pkg::W_STYPE];
      need    = cri_cmd_size(cmd);
      role    = s_r.ctrl[cri_pkg::CTRL_ROLE +: 2];
      link_ok = role == cri_pkg::ROLE_MASTER || role == cri_pkg::ROLE_ORIG;
      if (len < cri_pkg::LEN_MIN || len > cri_pkg::LEN_MAX) begin
         maj = cri_pkg::MAJ_LEN;
      end else if (mode[15:1] != 15'h0000) begin
         maj = cri_pkg::MAJ_MODE;
      end else if (cmd < cri_pkg::CMD_FIRST || cmd > cri_pkg::CMD_LAST) begin
         maj = cri_pkg::MAJ_RANGE;
      end else if (cmd >= cri_pkg::CMD_LINK && !link_ok) begin
         maj = cri_pkg::MAJ_ROLE;
      end else if (need == 16'h0000) begin
         maj = cri_pkg::MAJ_NOIMP;
      end else if (len != need) begin
         maj = cri_pkg::MAJ_LEN;
      end else begin
         maj = cri_pkg::MAJ_OK;
      end
      area_ok = 1'b1;
      unique case (styp)
         cri_pkg::TYP_REG: area = cri_pkg::AREA_REG;
         cri_pkg::TYP_AI:  area = cri_pkg::AREA_AI;
         cri_pkg::TYP_AQ:  area = cri_pkg::AREA_AQ;
         cri_pkg::TYP_DI:  area = cri_pkg::AREA_DI;
         cri_pkg::TYP_DQ:  area = cri_pkg::AREA_DQ;
         default: begin
            area    = cri_pkg::AREA_REG;
            area_ok = 1'b0;
         end
      endcase
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{i_avs_byteenable[b]}};
      end
      acc = (i_avs_read || i_avs_write) && !s_r.bus_ack;
   end

   // =====================================================================
   // Next state.
   always_comb begin
      s_nxt         = s_r;
      s_nxt.ack     = 1'b0;
      s_nxt.st_we   = 1'b0;
      s_nxt.bus_ack = acc;
      unique case (s_r.st)
         cri_pkg::D_IDLE: begin
            if (s_r.ctrl[cri_pkg::CTRL_EN] && lnk.req_valid) begin
               s_nxt.blk = lnk.req_block;
               s_nxt.ack = 1'b1;
               s_nxt.cnt = s_r.ctrl[cri_pkg::CTRL_DLY +: 8];
               s_nxt.st  = cri_pkg::D_EXEC;
            end
         end
         cri_pkg::D_EXEC: begin
            if (s_r.cnt == 8'h00) begin
               s_nxt.st = cri_pkg::D_RPT;
            end else begin
               s_nxt.cnt = s_r.cnt - 8'h01;
            end
         end
         cri_pkg::D_RPT: begin
            s_nxt.st       = cri_pkg::D_IDLE;
            s_nxt.last_cmd = cmd;
            s_nxt.last_sts = {maj == cri_pkg::MAJ_OK ? cri_pkg::SEC_NONE
                                                     : cri_pkg::SEC_ERR, maj};
            if (area_ok) begin
               s_nxt.st_we = 1'b1;
               s_nxt.area  = area;
               s_nxt.offs  = s_r.blk[cri_pkg::W_SOFF];
               s_nxt.word  = s_nxt.last_sts;
            end
         end
         default: begin
            s_nxt.st = cri_pkg::D_IDLE;
         end
      endcase
      // Register reads are answered on the second cycle of an access.
      if (acc && i_avs_read) begin
         unique case (i_avs_address)
            cri_pkg::REG_CTRL: s_nxt.rdata = s_r.ctrl;
            cri_pkg::REG_ISTS: s_nxt.rdata = {29'h0000_0000, s_r.ists};
            cri_pkg::REG_IMSK: s_nxt.rdata = {29'h0000_0000, s_r.imsk};
            cri_pkg::REG_LAST: s_nxt.rdata = {s_r.last_cmd, s_r.last_sts};
            default:           s_nxt.rdata = 32'h0000_0000;
         endcase
      end
      if (s_r.bus_ack && i_avs_write) begin
         unique case (i_avs_address)
            cri_pkg::REG_CTRL: begin
               s_nxt.ctrl = (s_r.ctrl & ~wmask) | (i_avs_writedata & wmask);
            end
            cri_pkg::REG_ISTS: begin
               s_nxt.ists = s_r.ists & ~(i_avs_writedata[2:0] & wmask[2:0]);
            end
            cri_pkg::REG_IMSK: begin
               s_nxt.imsk = (s_r.imsk & ~wmask[2:0]) | (i_avs_writedata[2:0] & wmask[2:0]);
            end
            default: begin
            end
         endcase
      end
      // A completion event in the clearing cycle still sets its bit.
      if (s_r.st == cri_pkg::D_RPT) begin
         s_nxt.ists[cri_pkg::EV_OK]   = s_nxt.ists[cri_pkg::EV_OK] | (maj == cri_pkg::MAJ_OK);
         s_nxt.ists[cri_pkg::EV_ERR]  = s_nxt.ists[cri_pkg::EV_ERR] | (maj != cri_pkg::MAJ_OK);
         s_nxt.ists[cri_pkg::EV_LOST] = s_nxt.ists[cri_pkg::EV_LOST] | !area_ok;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         s_r      <= '0;
         s_r.st   <= cri_pkg::D_IDLE;
         s_r.ctrl <= cri_pkg::CTRL_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // =====================================================================
   // Outputs.
   assign o_avs_readdata    = s_r.rdata;
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !s_r.bus_ack;
   assign o_irq             = |(s_r.ists & s_r.imsk);
   assign lnk.req_ack       = s_r.ack;
   assign lnk.st_we         = s_r.st_we;
   assign lnk.st_area       = s_r.area;
   assign lnk.st_offset     = s_r.offs;
   assign lnk.st_word       = s_r.word;

endmodule : cri_device_end

`default_nettype wire

// ==== src/cri_host_end.sv ====
`timescale 1ns/100ps
`default_nettype none

module cri_host_end (
   // Clock and reset.
   input  wire logic              i_clock,
   input  wire logic              i_sys_rst,
   // Request from the user.
   input  wire logic              i_start,
   input  wire logic [11:0][15:0] i_block,
   // Result to the user.
   output logic                   o_busy,
   output logic                   o_done,
   output logic                   o_ok,
   output logic                   o_fault,
   output logic [15:0]            o_status,
   output logic [2:0]             o_status_area,
   output logic [15:0]            o_status_offset,
   // Link to the device.
   cri_link_if.host               lnk
);

   // =====================================================================
   // State.
   typedef struct packed {
      cri_pkg::cri_host_state_e st;
      logic [11:0][15:0]        blk;
      logic                     valid;
      logic                     pend;
      logic [15:0]              tmr;
      logic                     done;
      logic                     ok;
      logic                     fault;
      logic [15:0]              sts;
      logic [2:0]               area;
      logic [15:0]              offs;
   } cri_host_s;

   cri_host_s s_r;
   cri_host_s s_nxt;
   logic      tick;
   logic      clr;
   logic      wait_md;

   assign wait_md = s_r.blk[cri_pkg::W_MODE][cri_pkg::MODE_BIT];

   cri_tick_div #(
      .DIV (cri_pkg::TICK_CYC)
   ) u_tick (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .i_clear   (clr),
      .o_tick    (tick)
   );

   // =====================================================================
   // Next state.
   always_comb begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      clr        = 1'b0;
      if (tick && s_r.tmr != 16'hffff) begin
         s_nxt.tmr = s_r.tmr + 16'h0001;
      end
      if (lnk.st_we) begin
         s_nxt.sts  = lnk.st_word;
         s_nxt.area = lnk.st_area;
         s_nxt.offs = lnk.st_offset;
         s_nxt.pend = 1'b0;
      end
      unique case (s_r.st)
         cri_pkg::H_IDLE: begin
            if (i_start && !s_r.pend) begin
               s_nxt.blk   = i_block;
               s_nxt.sts   = 16'h0000;
               s_nxt.valid = 1'b1;
               s_nxt.tmr   = 16'h0000;
               s_nxt.ok    = 1'b0;
               s_nxt.fault = 1'b0;
               s_nxt.st    = cri_pkg::H_ACK;
               clr         = 1'b1;
            end
         end
         cri_pkg::H_ACK: begin
            if (lnk.req_ack) begin
               s_nxt.valid = 1'b0;
               s_nxt.tmr   = 16'h0000;
               clr         = 1'b1;
               if (wait_md) begin
                  s_nxt.st = cri_pkg::H_RUN;
               end else begin
                  s_nxt.pend = 1'b1;
                  s_nxt.done = 1'b1;
                  s_nxt.ok   = 1'b1;
                  s_nxt.st   = cri_pkg::H_IDLE;
               end
            end else if (wait_md && s_r.tmr >= s_r.blk[cri_pkg::W_IDLE]) begin
               s_nxt.valid = 1'b0;
               s_nxt.done  = 1'b1;
               s_nxt.fault = 1'b1;
               s_nxt.st    = cri_pkg::H_IDLE;
            end
         end
         cri_pkg::H_RUN: begin
            if (lnk.st_we) begin
               s_nxt.done  = 1'b1;
               s_nxt.ok    = lnk.st_word[7:0] == cri_pkg::MAJ_OK;
               s_nxt.fault = lnk.st_word[7:0] != cri_pkg::MAJ_OK;
               s_nxt.st    = cri_pkg::H_IDLE;
            end else if (s_r.tmr >= s_r.blk[cri_pkg::W_MAXT]) begin
               s_nxt.done  = 1'b1;
               s_nxt.fault = 1'b1;
               s_nxt.st    = cri_pkg::H_IDLE;
            end
         end
         default: begin
            s_nxt.st = cri_pkg::H_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         s_r    <= '0;
         s_r.st <= cri_pkg::H_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // =====================================================================
   // Outputs.
   assign o_busy          = s_r.st != cri_pkg::H_IDLE || s_r.pend;
   assign o_done          = s_r.done;
   assign o_ok            = s_r.ok;
   assign o_fault         = s_r.fault;
   assign o_status        = s_r.sts;
   assign o_status_area   = s_r.area;
   assign o_status_offset = s_r.offs;
   assign lnk.req_valid   = s_r.valid;
   assign lnk.req_block   = s_r.blk;

endmodule : cri_host_end

`default_nettype wire

// ==== src/cri_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface cri_link_if;

   // Request from the controller CPU.
   logic              req_valid;
   logic [11:0][15:0] req_block;
   // Receipt acknowledge from the coprocessor task.
   logic              req_ack;
   // Status word write into requester memory.
   logic              st_we;
   logic [2:0]        st_area;
   logic [15:0]       st_offset;
   logic [15:0]       st_word;

   modport dev (
      input  req_valid,
      input  req_block,
      output req_ack,
      output st_we,
      output st_area,
      output st_offset,
      output st_word
   );

   modport host (
      output req_valid,
      output req_block,
      input  req_ack,
      input  st_we,
      input  st_area,
      input  st_offset,
      input  st_word
   );

endinterface : cri_link_if

`default_nettype wire

// ==== src/cri_pkg.sv ====
package cri_pkg;

   // ======================================================================
   // Timing.
   localparam int unsigned CLK_NS      = 40;
   localparam int unsigned UNIT_NS     = 100000;
   localparam int unsigned TICK_CYC    = UNIT_NS / CLK_NS;

   // ======================================================================
   // Command block layout, as word indices from the block base.
   localparam int unsigned BLK_WORDS   = 12;
   localparam int unsigned W_LEN       = 0;
   localparam int unsigned W_MODE      = 1;
   localparam int unsigned W_STYPE     = 2;
   localparam int unsigned W_SOFF      = 3;
   localparam int unsigned W_IDLE      = 4;
   localparam int unsigned W_MAXT      = 5;
   localparam int unsigned W_CMD       = 6;
   localparam logic [15:0] LEN_MIN     = 16'h0001;
   localparam logic [15:0] LEN_MAX     = 16'h0006;
   localparam int unsigned MODE_BIT    = 0;

   // ======================================================================
   // Command numbers.
   localparam logic [15:0] CMD_FIRST   = 16'h1770;
   localparam logic [15:0] CMD_LINK    = 16'h17d4;
   localparam logic [15:0] CMD_LAST    = 16'h1837;
   localparam logic [15:0] CMD_SETQ    = 16'h1771;
   localparam logic [15:0] CMD_CLRD    = 16'h1772;
   localparam logic [15:0] CMD_RDD     = 16'h1773;
   localparam logic [15:0] CMD_RDREG   = 16'h17d5;
   localparam logic [15:0] CMD_RDIN    = 16'h17d6;
   localparam logic [15:0] CMD_RDOUT   = 16'h17d7;
   localparam logic [15:0] CMD_RDQ     = 16'h17dd;
   localparam logic [15:0] CMD_BITWR   = 16'h17de;
   localparam logic [15:0] CMD_WRREG   = 16'h17df;
   localparam logic [15:0] CMD_WRIN    = 16'h17e0;
   localparam logic [15:0] CMD_WROUT   = 16'h17e1;

   // ======================================================================
   // Status word codes.
   localparam logic [7:0]  MAJ_OK      = 8'h01;
   localparam logic [7:0]  MAJ_LEN     = 8'h02;
   localparam logic [7:0]  MAJ_MODE    = 8'h03;
   localparam logic [7:0]  MAJ_RANGE   = 8'h04;
   localparam logic [7:0]  MAJ_ROLE    = 8'h05;
   localparam logic [7:0]  MAJ_NOIMP   = 8'h06;
   localparam logic [7:0]  SEC_NONE    = 8'h00;
   localparam logic [7:0]  SEC_ERR     = 8'h01;

   // ======================================================================
   // Status memory types and the areas they select.
   localparam logic [15:0] TYP_REG     = 16'h0008;
   localparam logic [15:0] TYP_AI      = 16'h000a;
   localparam logic [15:0] TYP_AQ      = 16'h000c;
   localparam logic [15:0] TYP_DI      = 16'h0010;
   localparam logic [15:0] TYP_DQ      = 16'h0012;
   localparam logic [2:0]  AREA_REG    = 3'h0;
   localparam logic [2:0]  AREA_AI     = 3'h1;
   localparam logic [2:0]  AREA_AQ     = 3'h2;
   localparam logic [2:0]  AREA_DI     = 3'h3;
   localparam logic [2:0]  AREA_DQ     = 3'h4;

   // ======================================================================
   // Port roles.
   localparam logic [1:0]  ROLE_MASTER = 2'h0;
   localparam logic [1:0]  ROLE_SLAVE  = 2'h1;
   localparam logic [1:0]  ROLE_RESP   = 2'h2;
   localparam logic [1:0]  ROLE_ORIG   = 2'h3;

   // ======================================================================
   // Device registers, byte addresses, fields and reset values.
   localparam logic [3:0]  REG_CTRL    = 4'h0;
   localparam logic [3:0]  REG_ISTS    = 4'h4;
   localparam logic [3:0]  REG_IMSK    = 4'h8;
   localparam logic [3:0]  REG_LAST    = 4'hc;
   localparam int unsigned CTRL_EN     = 0;
   localparam int unsigned CTRL_ROLE   = 1;
   localparam int unsigned CTRL_DLY    = 8;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam int unsigned EV_OK       = 0;
   localparam int unsigned EV_ERR      = 1;
   localparam int unsigned EV_LOST     = 2;
   localparam int unsigned EV_BITS     = 3;

   // ======================================================================
   // State codes.
   typedef enum logic [1:0] {
      D_IDLE = 2'b00,
      D_EXEC = 2'b01,
      D_RPT  = 2'b10
   } cri_dev_state_e;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_ACK  = 2'b01,
      H_RUN  = 2'b10
   } cri_host_state_e;

endpackage : cri_pkg

// ==== src/cri_tick_div.sv ====
`timescale 1ns/100ps
`default_nettype none

module cri_tick_div #(
   parameter int unsigned DIV = cri_pkg::TICK_CYC
) (
   // Clock and reset.
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   // Restart and tick.
   input  wire logic i_clear,
   output logic      o_tick
);

   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r + 16'h0001;
      if (i_clear || cnt_r == 16'(DIV - 1)) begin
         cnt_nxt = 16'h0000;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         cnt_r  <= 16'h0000;
         o_tick <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         o_tick <= !i_clear && cnt_r == 16'(DIV - 1);
      end
   end

endmodule : cri_tick_div

`default_nettype wire

// ==== tb/cri_link_properties.sv ====
`timescale 1ns/100ps
`default_nettype none

module cri_link_properties (
   // Clock and reset.
   input  wire logic              i_clock,
   input  wire logic              i_sys_rst,
   // Link signals.
   input  wire logic              req_valid,
   input  wire logic [11:0][15:0] req_block,
   input  wire logic              req_ack,
   input  wire logic              st_we,
   input  wire logic [2:0]        st_area,
   input  wire logic [15:0]       st_offset,
   input  wire logic [15:0]       st_word
);

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);

   // ======================================================================
   // Block latched when the device takes it.
   logic [11:0][15:0] blk_r;
   logic              lok;
   logic [15:0]       cmd;

   always_ff @(posedge i_clock) begin
      if (req_ack) begin
         blk_r <= req_block;
      end
   end

   assign lok = blk_r[0] >= 16'h0001 && blk_r[0] <= 16'h0006 && blk_r[1][15:1] == 15'h0;
   assign cmd = blk_r[cri_pkg::W_CMD];

   function automatic logic [2:0] area_of(input logic [15:0] t);
      case (t)
         cri_pkg::TYP_AI: area_of = cri_pkg::AREA_AI;
         cri_pkg::TYP_AQ: area_of = cri_pkg::AREA_AQ;
         cri_pkg::TYP_DI: area_of = cri_pkg::AREA_DI;
         cri_pkg::TYP_DQ: area_of = cri_pkg::AREA_DQ;
         default:         area_of = cri_pkg::AREA_REG;
      endcase
   endfunction : area_of

   // ======================================================================
   // Properties.
   a_ack_pulse: assert property (req_ack |-> req_valid ##1 !req_ack)
      else $error("ack without request or too long");
   a_valid_drop: assert property (req_ack |=> !req_valid)
      else $error("request held after ack");
   a_we_single: assert property (st_we |=> !st_we)
      else $error("status write longer than one cycle");
   a_status_nonzero: assert property (st_we |-> st_word != 16'h0000)
      else $error("status word zero");
   a_secondary_pair: assert property (st_we |-> (st_word[7:0] == cri_pkg::MAJ_OK)
      == (st_word[15:8] == cri_pkg::SEC_NONE))
      else $error("secondary code does not match major code");
   a_fail_major: assert property (st_we && st_word[7:0] != cri_pkg::MAJ_OK
      |-> st_word[7:0] > 8'h01)
      else $error("failure major code not above one");
   a_offset_copy: assert property (st_we |-> st_offset == blk_r[cri_pkg::W_SOFF])
      else $error("status offset differs from block");
   a_area_map: assert property (st_we |-> st_area == area_of(blk_r[cri_pkg::W_STYPE]))
      else $error("status area wrong");
   a_len_code: assert property (st_we && (blk_r[0] == 16'h0 || blk_r[0] > 16'h0006)
      |-> st_word[7:0] == cri_pkg::MAJ_LEN)
      else $error("bad length not reported");
   a_mode_code: assert property (st_we && blk_r[0] != 16'h0 && blk_r[0] <= 16'h0006
      && blk_r[1][15:1] != 15'h0 |-> st_word[7:0] == cri_pkg::MAJ_MODE)
      else $error("bad mode word not reported");
   a_range_code: assert property (st_we && lok && (cmd < cri_pkg::CMD_FIRST
      || cmd > cri_pkg::CMD_LAST) |-> st_word[7:0] == cri_pkg::MAJ_RANGE)
      else $error("out of range command not reported");

endmodule : cri_link_properties

`default_nettype wire

// ==== tb/cri_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module cri_tb_top;

   // ======================================================================
   // Stimulus, results and the two ends.
   logic              i_clock      = 1'b0;
   logic              i_sys_rst    = 1'b1;
   logic [3:0]        adr          = 4'h0;
   logic              rd           = 1'b0;
   logic              wr           = 1'b0;
   logic [31:0]       wdat         = 32'h0;
   logic              start        = 1'b0;
   logic [11:0][15:0] blk          = '0;
   logic [15:0]       tmo          = 16'h0004;
   logic [31:0]       rdat;
   logic [31:0]       q;
   logic              wreq, irq, busy, done, ok, fault;
   logic [15:0]       st, soff;
   logic [2:0]        sarea;
   int                n_errors     = 0;
   int                total_checks = 0;
   logic [15:0]       typ [6]      = '{cri_pkg::TYP_REG, cri_pkg::TYP_AI, cri_pkg::TYP_AQ,
                                       cri_pkg::TYP_DI, cri_pkg::TYP_DQ, 16'h0108};
   logic [2:0]        are [6]      = '{cri_pkg::AREA_REG, cri_pkg::AREA_AI, cri_pkg::AREA_AQ,
                                       cri_pkg::AREA_DI, cri_pkg::AREA_DQ, 3'h0};

   initial forever #20 i_clock = ~i_clock;

   cri_link_if u_cri_link_if ();
   cri_device_end u_cri_device_end (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
      .i_avs_byteenable(4'hf), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
      .o_irq(irq), .lnk(u_cri_link_if.dev));
   cri_host_end u_cri_host_end (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_start(start),
      .i_block(blk), .o_busy(busy), .o_done(done), .o_ok(ok), .o_fault(fault), .o_status(st),
      .o_status_area(sarea), .o_status_offset(soff), .lnk(u_cri_link_if.host));
   cri_link_properties u_cri_link_properties (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .req_valid(u_cri_link_if.req_valid), .req_block(u_cri_link_if.req_block),
      .req_ack(u_cri_link_if.req_ack), .st_we(u_cri_link_if.st_we),
      .st_area(u_cri_link_if.st_area), .st_offset(u_cri_link_if.st_offset),
      .st_word(u_cri_link_if.st_word));

   // ======================================================================
   // Shared tasks.
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic hang;
      n_errors++;
      $display("[FAIL] wait expected end seen timeout");
      close_out();
   endtask : hang

   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge i_clock);
      adr  <= a;
      wdat <= d;
      rd   <= !w;
      wr   <= w;
      for (k = 0; k < 20; k++) begin
         @(posedge i_clock);
         if (wreq === 1'b0) break;
      end
      if (k == 20) hang();
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic rq(input logic [15:0] len, md, cmd, input int ti, input logic [7:0] maj);
      logic [11:0][15:0] b;
      int k;
      b = '0;
      b[cri_pkg::W_LEN]   = len;
      b[cri_pkg::W_MODE]  = md;
      b[cri_pkg::W_STYPE] = typ[ti];
      b[cri_pkg::W_SOFF]  = 16'(ti * 299);
      b[cri_pkg::W_IDLE]  = tmo;
      b[cri_pkg::W_MAXT]  = tmo;
      b[cri_pkg::W_CMD]   = cmd;
      @(posedge i_clock);
      blk   <= b;
      start <= 1'b1;
      @(posedge i_clock);
      start <= 1'b0;
      for (k = 0; k < 30000; k++) begin
         @(posedge i_clock);
         if (busy === 1'b0) break;
      end
      if (k == 30000) hang();
      chk("ok", 32'(md[0] && maj != cri_pkg::MAJ_OK ? 2'h1 : 2'h2), 32'({ok, fault}));
      chk("status", maj == 8'h00 ? 32'h0 : {16'h0, maj == cri_pkg::MAJ_OK ?
          cri_pkg::SEC_NONE : cri_pkg::SEC_ERR, maj}, 32'(st));
      if (maj != 8'h00) begin
         chk("area", 32'(are[ti]), 32'(sarea));
         chk("offset", 32'(ti * 299), 32'(soff));
      end
   endtask : rq

   // ======================================================================
   // Scenarios.
   task automatic t_off;
      bus(1'b0, cri_pkg::REG_CTRL, 32'h0);
      chk("ctrl", cri_pkg::CTRL_RST, q);
      rq(16'h0001, 16'h0001, cri_pkg::CMD_CLRD, 0, 8'h00);
   endtask : t_off

   task automatic t_codes;
      bus(1'b1, cri_pkg::REG_CTRL, 32'h0000_0201);
      rq(16'h0000, 16'h0001, cri_pkg::CMD_CLRD, 1, cri_pkg::MAJ_LEN);
      rq(16'h0007, 16'h0001, cri_pkg::CMD_CLRD, 2, cri_pkg::MAJ_LEN);
      rq(16'h0001, 16'h0003, cri_pkg::CMD_CLRD, 3, cri_pkg::MAJ_MODE);
      rq(16'h0001, 16'h0001, 16'h176f, 4, cri_pkg::MAJ_RANGE);
      rq(16'h0001, 16'h0001, 16'h1838, 0, cri_pkg::MAJ_RANGE);
      rq(16'h0001, 16'h0001, cri_pkg::CMD_CLRD, 0, cri_pkg::MAJ_OK);
      rq(16'h0006, 16'h0001, cri_pkg::CMD_WRREG, 1, cri_pkg::MAJ_OK);
      rq(16'h0006, 16'h0001, cri_pkg::CMD_WRIN, 2, cri_pkg::MAJ_OK);
      rq(16'h0006, 16'h0001, cri_pkg::CMD_WROUT, 3, cri_pkg::MAJ_OK);
      rq(16'h0005, 16'h0001, cri_pkg::CMD_WRREG, 4, cri_pkg::MAJ_LEN);
      rq(16'h0001, 16'h0001, cri_pkg::CMD_FIRST, 0, cri_pkg::MAJ_NOIMP);
      rq(16'h0001, 16'h0001, cri_pkg::CMD_LAST, 1, cri_pkg::MAJ_NOIMP);
      rq(16'h0003, 16'h0001, cri_pkg::CMD_SETQ, 2, cri_pkg::MAJ_OK);
   endtask : t_codes

   task automatic t_roles;
      for (int r = 0; r < 4; r++) begin
         bus(1'b1, cri_pkg::REG_CTRL, 32'h0201 | (32'(r) << 1));
         rq(16'h0006, 16'h0001, cri_pkg::CMD_RDREG, r, (2'(r) == cri_pkg::ROLE_SLAVE ||
            2'(r) == cri_pkg::ROLE_RESP) ? cri_pkg::MAJ_ROLE : cri_pkg::MAJ_OK);
         rq(16'h0001, 16'h0001, cri_pkg::CMD_CLRD, r + 1, cri_pkg::MAJ_OK);
      end
   endtask : t_roles

   task automatic t_fire_and_forget_mode;
      bus(1'b1, cri_pkg::REG_CTRL, 32'h0000_0201);
      tmo = 16'h0000;
      rq(16'h0001, 16'h0000, cri_pkg::CMD_CLRD, 3, cri_pkg::MAJ_OK);
      tmo = 16'h0004;
   endtask : t_fire_and_forget_mode

   task automatic t_irq;
      bus(1'b1, cri_pkg::REG_IMSK, 32'h1);
      bus(1'b1, cri_pkg::REG_ISTS, 32'h7);
      rq(16'h0001, 16'h0001, cri_pkg::CMD_CLRD, 0, cri_pkg::MAJ_OK);
      bus(1'b0, cri_pkg::REG_LAST, 32'h0);
      chk("last", {cri_pkg::CMD_CLRD, 16'h0001}, q);
      bus(1'b0, cri_pkg::REG_ISTS, 32'h0);
      chk("ists", 32'h1, q);
      chk("irq", 32'h1, 32'(irq));
      bus(1'b1, cri_pkg::REG_ISTS, 32'h1);
      @(posedge i_clock);
      chk("irq", 32'h0, 32'(irq));
      rq(16'h0001, 16'h0001, cri_pkg::CMD_CLRD, 5, 8'h00);
      bus(1'b0, cri_pkg::REG_ISTS, 32'h0);
      chk("ists", 32'h5, q);
      chk("irq", 32'h1, 32'(irq));
      bus(1'b1, cri_pkg::REG_IMSK, 32'h4);
      @(posedge i_clock);
      chk("irq", 32'h1, 32'(irq));
   endtask : t_irq

   initial begin
      repeat (5) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      t_off();
      t_codes();
      t_roles();
      t_fire_and_forget_mode();
      t_irq();
      close_out();
   end

endmodule : cri_tb_top

`default_nettype wire
